// File: logic/fps_pkg.sv
package fps_pkg;

    // ****************************************
    // Array geometry
    // ****************************************
    localparam int FPS_SECT_N = 16;
    localparam int FPS_MASK_W = 17;
    localparam int FPS_PAGE_W = 12;
    localparam int FPS_BPTR_W = 9;
    localparam int FPS_BUF_AW = 10;
    localparam logic [8:0] FPS_BUF_LAST_STD = 9'h107;
    localparam logic [8:0] FPS_BUF_LAST_BIN = 9'h0ff;
    localparam int FPS_PAGE_LSB_STD = 9;
    localparam int FPS_PAGE_LSB_BIN = 8;

    // ****************************************
    // Command bytes
    // ****************************************
    localparam logic [7:0] FPS_OP_SECT_ERASE = 8'h7c;
    localparam logic [7:0] FPS_OP_CHIP_1 = 8'hc7;
    localparam logic [7:0] FPS_OP_CHIP_2 = 8'h94;
    localparam logic [7:0] FPS_OP_CHIP_3 = 8'h80;
    localparam logic [7:0] FPS_OP_CHIP_4 = 8'h9a;
    localparam logic [7:0] FPS_OP_PROG_BUF1 = 8'h82;
    localparam logic [7:0] FPS_OP_PROG_BUF2 = 8'h85;
    localparam logic [7:0] FPS_OP_PROT_1 = 8'h3d;
    localparam logic [7:0] FPS_OP_PROT_2 = 8'h2a;
    localparam logic [7:0] FPS_OP_PROT_3 = 8'h7f;
    localparam logic [7:0] FPS_OP_PROT_EN_4 = 8'ha9;
    localparam logic [7:0] FPS_OP_PROT_DIS_4 = 8'h9a;

    // ****************************************
    // Protection register encoding
    // ****************************************
    localparam logic [7:0] FPS_PROT_ON = 8'hff;
    localparam int FPS_S0A_LSB = 6;
    localparam int FPS_S0B_LSB = 4;
    localparam logic [1:0] FPS_PROT_PAIR = 2'h3;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [3:0] FPS_PIN_RST = 4'h9;
    localparam logic FPS_SW_PROT_RST = 1'b0;
    localparam logic FPS_WP_APPLIED_RST = 1'b0;

    // ****************************************
    // Timing
    // ****************************************
    localparam longint FPS_CLK_HZ = 64'd20000000;
    localparam longint FPS_SE_TIME_US = 64'd1000;
    localparam longint FPS_CE_TIME_US = 64'd10000;
    localparam longint FPS_PP_TIME_US = 64'd100;
    localparam int FPS_SE_CYC = int'((FPS_SE_TIME_US * FPS_CLK_HZ) / 64'd1000000);
    localparam int FPS_CE_CYC = int'((FPS_CE_TIME_US * FPS_CLK_HZ) / 64'd1000000);
    localparam int FPS_PP_CYC = int'((FPS_PP_TIME_US * FPS_CLK_HZ) / 64'd1000000);
    localparam int FPS_CNT_W = 24;

    typedef enum logic [1:0] {
        FPS_ST_IDLE,
        FPS_ST_STREAM,
        FPS_ST_WAIT
    } fps_state_type;

endpackage

// File: logic/fps_buf_if.sv
`timescale 1ns/1ps
interface fps_buf_if #(parameter int AW = 10, parameter int DW = 8);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic re;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;

    modport host (output we, waddr, wdata, re, raddr, input rdata);
    modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface

// File: logic/fps_buf_mem.sv
`timescale 1ns/1ps
module fps_buf_mem #(
    parameter int AW = 10,
    parameter int DW = 8
) (
    // Clock
    input wire logic clk,
    // Buffer port
    fps_buf_if.mem bus
);
    import fps_pkg::*;

    logic [DW-1:0] mem [0:(1<<AW)-1];

    if (AW < 1 || DW < 1) begin : g_chk
        $error("fps_buf_mem: bad geometry");
    end

    // Write port, no reset on storage
    always_ff @(posedge clk) begin
        if (bus.we) begin
            mem[bus.waddr] <= bus.wdata;
        end
    end

    // Read data registered, one cycle after re
    always_ff @(posedge clk) begin
        if (bus.re) begin
            bus.rdata <= mem[bus.raddr];
        end
    end
endmodule

// File: logic/fps_op_timer.sv
`timescale 1ns/1ps
module fps_op_timer #(
    parameter int CNT_W = 24
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic start,
    input wire logic [CNT_W-1:0] load,
    // Status
    output logic busy_r,
    output logic done_r
);
    import fps_pkg::*;

    logic [CNT_W-1:0] cnt_r;

    if (CNT_W < 2 || CNT_W > 32) begin : g_chk
        $error("fps_op_timer: CNT_W out of range");
    end

    // Self-timed countdown; a load of zero still takes one cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (start) begin
                cnt_r <= load;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                if (cnt_r <= CNT_W'(1)) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - CNT_W'(1);
                end
            end
        end
    end
endmodule

// File: logic/fps_seq.sv
`timescale 1ns/1ps
module fps_seq #(
    parameter int SE_CYC = fps_pkg::FPS_SE_CYC,
    parameter int CE_CYC = fps_pkg::FPS_CE_CYC,
    parameter int PP_CYC = fps_pkg::FPS_PP_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Serial pins, asynchronous to clk
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic si,
    input wire logic wp_n,
    // Configuration
    input wire logic page_mode_bin,
    input wire logic [8*fps_pkg::FPS_SECT_N-1:0] prot_reg_bytes,
    input wire logic [fps_pkg::FPS_SECT_N-1:0] lock_sector,
    // Status
    output logic busy_r,
    output logic prot_enabled_r,
    output logic prot_reg_writable_r,
    // Array sector erase
    output logic arr_erase_r,
    output logic [fps_pkg::FPS_MASK_W-1:0] arr_erase_mask_r,
    // Array page program
    output logic arr_prog_r,
    output logic [fps_pkg::FPS_PAGE_W-1:0] arr_page_r,
    output logic arr_wvalid_r,
    output logic [8:0] arr_waddr_r,
    output logic [7:0] arr_wdata_r
);
    import fps_pkg::*;

    // ****************************************
    // Elaboration checks
    // ****************************************
    // Program time must outlast the buffer stream
    if (SE_CYC < 1 || CE_CYC < 1 || PP_CYC < 300 ||
        SE_CYC >= (1 << FPS_CNT_W) || CE_CYC >= (1 << FPS_CNT_W) ||
        PP_CYC >= (1 << FPS_CNT_W)) begin : g_chk
        $error("fps_seq: cycle count out of range");
    end

    // ****************************************
    // Functions
    // ****************************************
    // Page field from the three address bytes, per page mode
    function automatic logic [FPS_PAGE_W-1:0] page_of(input logic [23:0] a, input logic bin);
        logic [FPS_PAGE_W-1:0] p;
        p = bin ? a[FPS_PAGE_LSB_BIN +: FPS_PAGE_W] : a[FPS_PAGE_LSB_STD +: FPS_PAGE_W];
        return p;
    endfunction

    // One-hot sector: bit0 = 0a, bit1 = 0b, bit k+1 = sector k
    function automatic logic [FPS_MASK_W-1:0] sector_hot(input logic [FPS_PAGE_W-1:0] p);
        logic [FPS_MASK_W-1:0] m;
        m = '0;
        if (p[11:8] != 4'h0) begin
            m[{1'b0, p[11:8]} + 5'h01] = 1'b1; // Five bits so sector 15 lands on bit 16
        end else if (p[7:3] == 5'h00) begin
            m[0] = 1'b1;
        end else begin
            m[1] = 1'b1;
        end
        return m;
    endfunction

    // Protection register bytes to a sector mask
    function automatic logic [FPS_MASK_W-1:0] prot_mask(input logic [8*FPS_SECT_N-1:0] b);
        logic [FPS_MASK_W-1:0] m;
        m = '0;
        m[0] = (b[FPS_S0A_LSB +: 2] == FPS_PROT_PAIR);
        m[1] = (b[FPS_S0B_LSB +: 2] == FPS_PROT_PAIR);
        for (int k = 1; k < FPS_SECT_N; k++) begin
            m[k+1] = (b[8*k +: 8] == FPS_PROT_ON);
        end
        return m;
    endfunction

    // Buffer pointer advance with wrap at the page size
    function automatic logic [FPS_BPTR_W-1:0] next_ptr(input logic [FPS_BPTR_W-1:0] p,
                                                        input logic bin);
        logic [FPS_BPTR_W-1:0] last;
        last = bin ? FPS_BUF_LAST_BIN : FPS_BUF_LAST_STD;
        return (p >= last) ? '0 : p + FPS_BPTR_W'(1);
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Order {wp_n, si, sclk, cs_n}; idle levels at reset
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic sclk_d_r;
    logic cs_d_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_r <= FPS_PIN_RST;
            pin_s2_r <= FPS_PIN_RST;
            sclk_d_r <= FPS_PIN_RST[1];
            cs_d_r <= FPS_PIN_RST[0];
        end else begin
            pin_s1_r <= {wp_n, si, sclk, cs_n};
            pin_s2_r <= pin_s1_r;
            sclk_d_r <= pin_s2_r[1];
            cs_d_r <= pin_s2_r[0];
        end
    end

    logic cs_act;
    logic cs_rise;
    logic sclk_rise;
    logic si_s;
    logic wp_low;

    // Serial clock must run well below clk/4 for edge detection
    assign cs_act = ~pin_s2_r[0];
    assign cs_rise = pin_s2_r[0] & ~cs_d_r;
    assign sclk_rise = pin_s2_r[1] & ~sclk_d_r;
    assign si_s = pin_s2_r[2];
    assign wp_low = ~pin_s2_r[3];

    // ****************************************
    // Serial shifter and byte capture
    // ****************************************
    logic [6:0] shreg_r;
    logic [2:0] bit_cnt_r;
    logic [2:0] byte_cnt_r;
    logic [7:0] opc_r;
    logic [7:0] b1_r;
    logic [7:0] b2_r;
    logic [7:0] b3_r;
    logic wp_low_seen_r;
    logic byte_done;
    logic [7:0] new_byte;
    fps_state_type state_r;
    logic idle;

    assign idle = (state_r == FPS_ST_IDLE);
    assign byte_done = cs_act & sclk_rise & (bit_cnt_r == 3'h7);
    assign new_byte = {shreg_r, si_s};

    // Bit and byte counts; counting only inside a chip select frame
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shreg_r <= '0;
            bit_cnt_r <= '0;
            byte_cnt_r <= '0;
        end else if (!cs_act) begin
            bit_cnt_r <= '0;
            byte_cnt_r <= '0;
        end else if (sclk_rise) begin
            shreg_r <= {shreg_r[5:0], si_s};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7 && byte_cnt_r != 3'h4) begin
                byte_cnt_r <= byte_cnt_r + 3'h1; // Saturates at four: later bytes not counted
            end
        end
    end

    // Opcode and the three following bytes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            opc_r <= '0;
            b1_r <= '0;
            b2_r <= '0;
            b3_r <= '0;
        end else if (byte_done) begin
            case (byte_cnt_r)
                3'h0: opc_r <= new_byte;
                3'h1: b1_r <= new_byte;
                3'h2: b2_r <= new_byte;
                3'h3: b3_r <= new_byte;
                default: ;
            endcase
        end
    end

    // Write-protect seen low at any time within the frame
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_low_seen_r <= 1'b0;
        end else if (!cs_act) begin
            wp_low_seen_r <= 1'b0;
        end else if (wp_low) begin
            wp_low_seen_r <= 1'b1;
        end
    end

    // ****************************************
    // Buffer fill
    // ****************************************
    fps_buf_if #(.AW(FPS_BUF_AW), .DW(8)) bif ();

    logic is_prog;
    logic wr_buf_r;
    logic [FPS_BPTR_W-1:0] wr_ptr_r;
    logic [FPS_BPTR_W-1:0] start_ptr;
    logic buf_we;

    assign is_prog = (opc_r == FPS_OP_PROG_BUF1) || (opc_r == FPS_OP_PROG_BUF2);
    // Starting byte: 9 bits in standard mode, 8 in binary mode
    assign start_ptr = page_mode_bin ? {1'b0, new_byte} : {b2_r[0], new_byte};
    // Buffers are frozen while an array operation runs
    assign buf_we = byte_done & (byte_cnt_r == 3'h4) & is_prog & idle;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_buf_r <= 1'b0;
            wr_ptr_r <= '0;
        end else if (byte_done && byte_cnt_r == 3'h3) begin
            wr_buf_r <= (opc_r == FPS_OP_PROG_BUF2);
            wr_ptr_r <= start_ptr;
        end else if (buf_we) begin
            wr_ptr_r <= next_ptr(wr_ptr_r, page_mode_bin);
        end
    end

    assign bif.we = buf_we;
    assign bif.waddr = {wr_buf_r, wr_ptr_r};
    assign bif.wdata = new_byte;

    fps_buf_mem #(.AW(FPS_BUF_AW), .DW(8)) u_mem (
        .clk(clk),
        .bus(bif.mem)
    );

    // ****************************************
    // Command decode at chip select rising
    // ****************************************
    logic sw_prot_r;
    logic wp_applied_r;
    logic erase_run_r;
    logic prot_eff;
    logic [23:0] addr;
    logic [FPS_PAGE_W-1:0] page;
    logic [FPS_MASK_W-1:0] hot;
    logic [FPS_MASK_W-1:0] blocked;
    logic cmd_ok;
    logic seq_prot;
    logic do_sect;
    logic do_chip;
    logic do_prog;
    logic do_prot_en;
    logic do_prot_dis;

    assign prot_eff = sw_prot_r | wp_applied_r;
    assign addr = {b1_r, b2_r, b3_r};
    assign page = page_of(addr, page_mode_bin);
    assign hot = sector_hot(page);
    // Locks always hold; marked sectors only while protection is on
    assign blocked = (prot_eff ? prot_mask(prot_reg_bytes) : '0)
                   | {lock_sector[FPS_SECT_N-1:1], lock_sector[0], lock_sector[0]};
    // Whole bytes only, four or more, device idle
    assign cmd_ok = cs_rise & idle & (bit_cnt_r == 3'h0) & (byte_cnt_r == 3'h4);
    assign seq_prot = (opc_r == FPS_OP_PROT_1) && (b1_r == FPS_OP_PROT_2) &&
                      (b2_r == FPS_OP_PROT_3);
    assign do_sect = cmd_ok && (opc_r == FPS_OP_SECT_ERASE) && ((hot & ~blocked) != '0);
    assign do_chip = cmd_ok && (opc_r == FPS_OP_CHIP_1) && (b1_r == FPS_OP_CHIP_2) &&
                     (b2_r == FPS_OP_CHIP_3) && (b3_r == FPS_OP_CHIP_4) &&
                     (~blocked != '0);
    assign do_prog = cmd_ok && is_prog && ((hot & blocked) == '0);
    assign do_prot_en = cmd_ok && seq_prot && (b3_r == FPS_OP_PROT_EN_4);
    assign do_prot_dis = cmd_ok && seq_prot && (b3_r == FPS_OP_PROT_DIS_4) &&
                         !wp_low_seen_r && !wp_low;

    // Software protection flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sw_prot_r <= FPS_SW_PROT_RST;
        end else if (do_prot_en) begin
            sw_prot_r <= 1'b1;
        end else if (do_prot_dis) begin
            sw_prot_r <= 1'b0;
        end
    end

    // Pin protection frozen while an erase runs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_applied_r <= FPS_WP_APPLIED_RST;
        end else if (!erase_run_r && !do_sect && !do_chip) begin
            wp_applied_r <= wp_low;
        end
    end

    // Status outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prot_enabled_r <= 1'b0;
            prot_reg_writable_r <= 1'b1;
        end else begin
            prot_enabled_r <= prot_eff;
            prot_reg_writable_r <= ~wp_applied_r;
        end
    end

    // ****************************************
    // Self-timed operations
    // ****************************************
    logic tmr_start;
    logic [FPS_CNT_W-1:0] tmr_load;
    logic tmr_done;

    assign tmr_start = do_sect | do_chip | do_prog;
    always_comb begin
        if (do_chip) begin
            tmr_load = FPS_CNT_W'(CE_CYC);
        end else if (do_sect) begin
            tmr_load = FPS_CNT_W'(SE_CYC);
        end else begin
            tmr_load = FPS_CNT_W'(PP_CYC);
        end
    end

    fps_op_timer #(.CNT_W(FPS_CNT_W)) u_tmr (
        .clk(clk),
        .rst_b(rst_b),
        .start(tmr_start),
        .load(tmr_load),
        .busy_r(busy_r),
        .done_r(tmr_done)
    );

    // Erase request pulses and the erase-running flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            arr_erase_r <= 1'b0;
            arr_erase_mask_r <= '0;
            erase_run_r <= 1'b0;
        end else begin
            arr_erase_r <= do_sect | do_chip;
            if (do_sect) begin
                arr_erase_mask_r <= hot & ~blocked;
                erase_run_r <= 1'b1;
            end else if (do_chip) begin
                arr_erase_mask_r <= ~blocked;
                erase_run_r <= 1'b1;
            end else if (tmr_done) begin
                erase_run_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // Sequencer and buffer stream to array
    // ****************************************
    logic rd_buf_r;
    logic [FPS_BPTR_W-1:0] rd_ptr_r;
    logic [FPS_BPTR_W-1:0] rd_last;
    logic rd_pend_r;
    logic [FPS_BPTR_W-1:0] rd_addr_d_r;
    logic rd_en;

    assign rd_last = page_mode_bin ? FPS_BUF_LAST_BIN : FPS_BUF_LAST_STD;
    assign rd_en = (state_r == FPS_ST_STREAM);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= FPS_ST_IDLE;
            rd_buf_r <= 1'b0;
            rd_ptr_r <= '0;
            arr_prog_r <= 1'b0;
            arr_page_r <= '0;
        end else begin
            arr_prog_r <= 1'b0;
            case (state_r)
                FPS_ST_IDLE: begin
                    if (do_prog) begin
                        arr_prog_r <= 1'b1; // Erase page to ones, then program
                        arr_page_r <= page;
                        rd_buf_r <= (opc_r == FPS_OP_PROG_BUF2);
                        rd_ptr_r <= '0;
                        state_r <= FPS_ST_STREAM;
                    end else if (do_sect || do_chip) begin
                        state_r <= FPS_ST_WAIT;
                    end
                end
                FPS_ST_STREAM: begin
                    rd_ptr_r <= rd_ptr_r + FPS_BPTR_W'(1);
                    if (rd_ptr_r == rd_last) begin
                        state_r <= FPS_ST_WAIT;
                    end
                end
                FPS_ST_WAIT: begin
                    if (tmr_done) begin
                        state_r <= FPS_ST_IDLE;
                    end
                end
                default: state_r <= FPS_ST_IDLE;
            endcase
        end
    end

    assign bif.re = rd_en;
    assign bif.raddr = {rd_buf_r, rd_ptr_r};

    // Read data lags one cycle; valid and address pipelined to match
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_pend_r <= 1'b0;
            rd_addr_d_r <= '0;
            arr_wvalid_r <= 1'b0;
            arr_waddr_r <= '0;
            arr_wdata_r <= '0;
        end else begin
            rd_pend_r <= rd_en;
            rd_addr_d_r <= rd_ptr_r;
            arr_wvalid_r <= rd_pend_r;
            arr_waddr_r <= rd_addr_d_r;
            arr_wdata_r <= rd_pend_r ? bif.rdata : 8'h00;
        end
    end
endmodule

// File: tb/fps_host.sv
`timescale 1ns/1ps
module fps_host (
    // Serial pins
    output logic cs_n,
    output logic sclk,
    output logic si
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    // Mode 0 frame; slow phases so the pin synchronisers keep up
    task automatic frame(input logic [63:0] d, input int n);
        cs_n = 1'b0;
        for (int i = 0; i < 8 * n; i++) begin
            si = d[63-i];
            #200 sclk = 1'b1;
            #200 sclk = 1'b0;
        end
        #200 cs_n = 1'b1;
        si = ~si;
        #400;
    endtask
endmodule

// File: tb/fps_seq_sva.sv
`timescale 1ns/1ps
module fps_seq_sva (
    // Clock, reset, pin
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wp_n,
    // Status and array side
    input wire logic busy_r,
    input wire logic prot_enabled_r,
    input wire logic prot_reg_writable_r,
    input wire logic arr_erase_r,
    input wire logic arr_prog_r,
    input wire logic arr_wvalid_r,
    input wire logic [8:0] arr_waddr_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic ers_r;
    // Erase in flight, pin protection must wait for it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) ers_r <= 1'b0;
        else if (arr_erase_r) ers_r <= 1'b1;
        else if (!busy_r) ers_r <= 1'b0;
    end
    sequence s_stream_head;
        busy_r ##2 arr_wvalid_r && arr_waddr_r == 9'h000;
    endsequence
    property p_start; $rose(busy_r) |-> arr_erase_r || arr_prog_r; endproperty
    property p_erase; arr_erase_r |-> busy_r ##1 !arr_erase_r; endproperty
    property p_refuse; busy_r && $past(busy_r) |-> !arr_erase_r && !arr_prog_r; endproperty
    property p_prog; arr_prog_r |-> s_stream_head; endproperty
    property p_step; arr_wvalid_r ##1 arr_wvalid_r |-> arr_waddr_r == $past(arr_waddr_r) + 9'h001;
    endproperty
    property p_wp_hold; ers_r && busy_r |-> !$fell(prot_reg_writable_r); endproperty
    property p_wp_on; (!wp_n && !busy_r) [*8] |-> prot_enabled_r && !prot_reg_writable_r;
    endproperty
    property p_wp_off; (wp_n && !busy_r) [*8] |-> prot_reg_writable_r; endproperty
    a_start: assert property (p_start) else $error("busy without operation");
    a_erase: assert property (p_erase) else $error("erase pulse bad");
    a_refuse: assert property (p_refuse) else $error("command taken while busy");
    a_prog: assert property (p_prog) else $error("program stream bad");
    a_step: assert property (p_step) else $error("stream address skipped");
    a_wp_hold: assert property (p_wp_hold) else $error("pin applied mid erase");
    a_wp_on: assert property (p_wp_on) else $error("pin protection absent");
    a_wp_off: assert property (p_wp_off) else $error("register stays locked");
endmodule
bind fps_seq fps_seq_sva u_fps_seq_sva (.clk, .rst_b, .wp_n, .busy_r, .prot_enabled_r,
    .prot_reg_writable_r, .arr_erase_r, .arr_prog_r, .arr_wvalid_r, .arr_waddr_r);

// File: tb/fps_seq_tb.sv
`timescale 1ns/1ps
module fps_seq_tb;
    import fps_pkg::*;
    logic clk, rst_b, cs_n, sclk, si, wp_n, page_mode_bin, busy_r, prot_enabled_r;
    logic prot_reg_writable_r, arr_erase_r, arr_prog_r, arr_wvalid_r;
    logic [8*FPS_SECT_N-1:0] prot_reg_bytes;
    logic [FPS_SECT_N-1:0] lock_sector;
    logic [FPS_MASK_W-1:0] arr_erase_mask_r, ers_m;
    logic [FPS_PAGE_W-1:0] arr_page_r;
    logic [8:0] arr_waddr_r;
    logic [7:0] arr_wdata_r;
    logic [7:0] wbuf [0:263];
    logic [11:0] pg [7] = '{12'h000, 12'h007, 12'h008, 12'h0f8, 12'h1ff, 12'hf00, 12'h300};
    logic [16:0] mk [7] = '{17'h1, 17'h1, 17'h2, 17'h2, 17'h4, 17'h10000, 17'h10};
    int n_errors = 0, compares = 0, ers_n = 0;
    fps_seq #(.SE_CYC(400), .CE_CYC(30), .PP_CYC(300)) u_fps_seq (.clk, .rst_b, .cs_n, .sclk,
        .si, .wp_n, .page_mode_bin, .prot_reg_bytes, .lock_sector, .busy_r, .prot_enabled_r,
        .prot_reg_writable_r, .arr_erase_r, .arr_erase_mask_r, .arr_prog_r, .arr_page_r,
        .arr_wvalid_r, .arr_waddr_r, .arr_wdata_r);
    fps_host u_fps_host (.cs_n, .sclk, .si);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Catch one-cycle erase pulses and the streamed page bytes
    always @(posedge clk) begin
        ers_n += int'(arr_erase_r === 1'b1);
        if (arr_erase_r === 1'b1) ers_m = arr_erase_mask_r;
        if (arr_wvalid_r === 1'b1) wbuf[arr_waddr_r] = arr_wdata_r;
    end
    task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmd(input logic [63:0] d, input int n);
        @(posedge clk);
        #1 u_fps_host.frame(d, n);
    endtask
    // Bounded wait for the array to go quiet
    task automatic idle();
        repeat (8) @(posedge clk);
        for (int k = 0; k < 5000 && busy_r !== 1'b0; k++) @(posedge clk);
        repeat (8) @(posedge clk);
        #1;
        check("busy end", busy_r, 0);
    endtask
    task automatic test_done();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #3000000 n_errors++;
        test_done();
    end
    initial begin
        {rst_b, wp_n, page_mode_bin, prot_reg_bytes, lock_sector} = '0;
        wp_n = 1'b1;
        repeat (4) @(posedge clk);
        #1 rst_b = 1'b1;
        check("writable", prot_reg_writable_r, 1);
        foreach (pg[i]) begin
            page_mode_bin = (i == 6);
            ers_n = 0;
            cmd({8'h7c, i == 6 ? {4'h0, pg[i], 8'h00} : {3'h0, pg[i], 9'h000}, 32'h0},
                4);
            idle();
            check("sector mask", ers_m, mk[i]);
            check("erase count", ers_n, 1);
        end
        page_mode_bin = 1'b0;
        ers_n = 0;
        cmd(64'h7c00_2000_0000_0000, 4);
        wp_n = 1'b0;
        cmd(64'h7c00_4000_0000_0000, 4);
        check("writable mid erase", prot_reg_writable_r, 1);
        idle();
        check("refused", ers_n, 1);
        check("pin prot", {prot_enabled_r, prot_reg_writable_r}, 2'h2);
        cmd(64'h3d2a_7f9a_0000_0000, 4);
        wp_n = 1'b1;
        idle();
        check("pin released", prot_enabled_r, 0);
        prot_reg_bytes[23:16] = 8'hff;
        lock_sector[4] = 1'b1;
        cmd(64'h3d2a_7fa9_0000_0000, 4);
        idle();
        check("enabled", prot_enabled_r, 1);
        ers_n = 0;
        cmd(64'h7c04_0000_0000_0000, 4);
        idle();
        check("blocked", ers_n, 0);
        cmd(64'hc794_809a_5500_0000, 5);
        idle();
        check("chip mask", ers_m, 17'h1ffd7);
        wp_n = 1'b0;
        cmd(64'h3d2a_7f9a_0000_0000, 4);
        wp_n = 1'b1;
        idle();
        check("disable ignored", prot_enabled_r, 1);
        cmd(64'h3d2a_7f9a_0000_0000, 4);
        idle();
        check("disabled", prot_enabled_r, 0);
        cmd({8'h82, 3'h0, 12'h005, 9'h106, 32'haabb_cc00}, 7);
        idle();
        check("std page", {arr_page_r, wbuf[262], wbuf[263], wbuf[0]},
              36'h005_aabbcc);
        page_mode_bin = 1'b1;
        cmd({8'h85, 4'h0, 12'h00a, 8'hff, 32'h1122_0000}, 6);
        idle();
        check("bin page", {arr_page_r, wbuf[255], wbuf[0]}, 28'h00a_1122);
        test_done();
    end
endmodule
